// ==== hdl/erxst_top.sv ====
// Summary of operation
// (RQ1) Every counter is cleared 38 clocks after reset is released.
// (RQ2) With the gigabit enable set, a write subtracts its value from the counter.
// (RQ3) In that mode a value larger than the counter leaves zero behind.
// (RQ4) With the gigabit enable clear, a write loads the counter directly.
// (RQ5) Software writes counters only as whole 32-bit words.
// (RQ6) When enabled, the pending flag rises while any counter is at or above half scale.
// (RQ7) The pending flag falls only once software has written every counter below half scale; the code also drops it on enable clear or counter wrap.
// (RQ8) Counters are 32-bit, mapped, and wrap from all ones to zero.
// (RQ9) The good counter counts accepted frames of legal length with no error.
// (RQ10) The broadcast counter counts such good frames sent to the all-ones address.
// (RQ11) The group counter counts such good frames sent to other group addresses.
// (RQ12) Overruns neither block nor cause any of these increments.
// (RQ13) An even nibble count with a bad check sequence is a checksum error.
// (RQ14) An odd nibble count failing the check without the last nibble is misaligned.
// (RQ15) Any receive error bit during the frame marks a code error.
// (RQ16) A frame increment and a write in the same cycle both take effect.
`timescale 1ns/1ps
`default_nettype none
module erxst_top (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Receive path report, same clock domain except the error pin
    input wire logic rx_active_i,
    input wire logic phy_receive_error_in_i,
    input wire logic rx_done_i,
    input wire logic rx_addr_match_i,
    input wire logic rx_promisc_i,
    input wire logic [47:0] rx_dest_addr_i,
    input wire logic [15:0] rx_length_i,
    input wire logic rx_odd_nibbles_i,
    input wire logic rx_fcs_ok_i,
    input wire logic rx_fcs_trunc_ok_i,
    input wire logic rx_overrun_i,
    // Status
    output logic counter_irq_pending_o,
    output logic irq_o
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [31:0] link_control_register_q;
    logic [erxst_pkg::EV_WIDTH-1:0] stat_q;
    logic [erxst_pkg::EV_WIDTH-1:0] stat_d;
    logic [erxst_pkg::EV_WIDTH-1:0] mask_q;
    logic [15:0] max_rx_frame_length_q;
    logic [5:0] clr_cnt_q;
    logic clr_pend_q;
    logic code_err_q;
    logic [2:0] inc_q;
    logic [31:0] reg_rdata_q;
    logic rd_cnt_q;
    logic pend_q;
    logic irq_q;
    logic rx_err_meta_q;
    logic rx_err_sync_q;
    erxst_pkg::erxst_rx_state_type rx_state_q;

    erxst_cnt_if cif ();

    // Status and mask read back behind a fixed 28-bit zero pad
    if (erxst_pkg::EV_WIDTH != 4) begin : g_ev_check
        $error("Status width must be four bits");
    end

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic [1:0] erxst_cnt_index(input logic [7:0] addr);
        case (addr)
            erxst_pkg::GOOD_OFS: erxst_cnt_index = 2'd0;
            erxst_pkg::BCAST_OFS: erxst_cnt_index = 2'd1;
            erxst_pkg::GROUP_OFS: erxst_cnt_index = 2'd2;
            default: erxst_cnt_index = 2'd3;
        endcase
    endfunction : erxst_cnt_index

    // Index 3 stands for any address outside the counter bank
    wire logic [1:0] addr_idx = erxst_cnt_index(reg_addr_i);
    wire logic addr_is_cnt = addr_idx != 2'd3;
    wire logic wr_ctrl = reg_wr_i && (reg_addr_i == erxst_pkg::CTRL_OFS);
    wire logic wr_mask = reg_wr_i && (reg_addr_i == erxst_pkg::MASK_OFS);
    wire logic wr_maxlen = reg_wr_i && (reg_addr_i == erxst_pkg::MAXLEN_OFS);
    wire logic rd_stat = reg_rd_i && (reg_addr_i == erxst_pkg::STAT_OFS);
    wire logic gmii_en = link_control_register_q[erxst_pkg::CTRL_GMII_BIT];
    wire logic irq_en = link_control_register_q[erxst_pkg::CTRL_IRQEN_BIT];

    // ----------------------------------------------------------------
    // Frame classification
    // ----------------------------------------------------------------
    // Code errors can only be seen while the frame streams, so they are latched here
    wire logic crc_err = !rx_odd_nibbles_i && !rx_fcs_ok_i; // RQ13
    wire logic align_err = rx_odd_nibbles_i && !rx_fcs_trunc_ok_i; // RQ14
    wire logic any_err = crc_err || align_err || code_err_q || rx_err_sync_q;
    wire logic len_ok = (rx_length_i >= erxst_pkg::MIN_FRAME_LEN)
                        && (rx_length_i <= max_rx_frame_length_q);
    // Overrun is deliberately not an input term of the qualifier
    wire logic frame_good = rx_done_i && (rx_addr_match_i || rx_promisc_i)
                            && len_ok && !any_err; // RQ9 RQ12
    wire logic is_bcast = rx_dest_addr_i == erxst_pkg::BCAST_ADDR;
    wire logic is_group = rx_dest_addr_i[0];
    wire logic [2:0] inc_d = {frame_good && is_group && !is_bcast, // RQ11
                              frame_good && is_bcast, // RQ10
                              frame_good};
    wire logic half_any = |cif.half;
    wire logic rx_unused = rx_overrun_i;

    // ----------------------------------------------------------------
    // Counter bank hookup
    // ----------------------------------------------------------------
    // Reads and writes share one decoded index
    assign cif.wr_idx = addr_idx;
    assign cif.wr_en = reg_wr_i && addr_is_cnt; // RQ5
    assign cif.wr_val = reg_wdata_i;
    assign cif.inc = inc_q;
    assign cif.clr = clr_pend_q && (clr_cnt_q == 6'(erxst_pkg::CLEAR_DELAY_CYC - 1));
    assign cif.rd_idx = addr_idx;

    erxst_counter_bank #(
        .NUM(erxst_pkg::NUM_CNT)
    ) u_bank (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .gmii_en_i(gmii_en),
        .cif(cif.bank)
    );

    // ----------------------------------------------------------------
    // Post-reset clear timer
    // ----------------------------------------------------------------
    // The timer is six bits wide, which bounds the clear delay
    if (erxst_pkg::CLEAR_DELAY_CYC < 1 || erxst_pkg::CLEAR_DELAY_CYC > 63) begin : g_delay_check
        $error("Clear delay does not fit the timer");
    end

    // Counts from the first edge after release; the clear lands on edge 38
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            clr_cnt_q <= 6'h00;
            clr_pend_q <= 1'b1;
        end else if (clr_pend_q) begin
            clr_cnt_q <= clr_cnt_q + 6'h01; // RQ1
            clr_pend_q <= !cif.clr;
        end
    end

    // ----------------------------------------------------------------
    // Receive error capture
    // ----------------------------------------------------------------
    // Two flops, since the error pin is not timed to the system clock
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rx_err_meta_q <= 1'b0;
            rx_err_sync_q <= 1'b0;
        end else begin
            rx_err_meta_q <= phy_receive_error_in_i;
            rx_err_sync_q <= rx_err_meta_q;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rx_state_q <= erxst_pkg::ST_IDLE;
            code_err_q <= 1'b0;
        end else begin
            case (rx_state_q)
                erxst_pkg::ST_IDLE: begin
                    code_err_q <= rx_err_sync_q;
                    if (rx_active_i) begin
                        rx_state_q <= erxst_pkg::ST_RX;
                    end
                end
                erxst_pkg::ST_RX: begin
                    code_err_q <= code_err_q || rx_err_sync_q; // RQ15
                    if (rx_done_i) begin
                        rx_state_q <= erxst_pkg::ST_CHECK;
                    end
                end
                erxst_pkg::ST_CHECK: begin
                    code_err_q <= 1'b0;
                    rx_state_q <= rx_active_i ? erxst_pkg::ST_RX : erxst_pkg::ST_IDLE;
                end
                default: begin
                    rx_state_q <= erxst_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Only the two defined control bits are kept; the rest read back as zero
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            link_control_register_q <= 32'h0000_0000;
        end else if (wr_ctrl) begin
            link_control_register_q <= {30'h0000_0000, reg_wdata_i[1:0]};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            mask_q <= {erxst_pkg::EV_WIDTH{1'b0}};
        end else if (wr_mask) begin
            mask_q <= reg_wdata_i[erxst_pkg::EV_WIDTH-1:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            max_rx_frame_length_q <= erxst_pkg::MAXLEN_RESET;
        end else if (wr_maxlen) begin
            max_rx_frame_length_q <= reg_wdata_i[15:0];
        end
    end

    // Increments are registered to cut the path from the frame report into the adders
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            inc_q <= 3'h0;
        end else begin
            inc_q <= inc_d;
        end
    end

    // ----------------------------------------------------------------
    // Sticky status and interrupt
    // ----------------------------------------------------------------
    // New events win over a clearing read in the same cycle
    always_comb begin
        stat_d = rd_stat ? {erxst_pkg::EV_WIDTH{1'b0}} : stat_q;
        stat_d = stat_d | {half_any && irq_en, inc_q};
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            stat_q <= {erxst_pkg::EV_WIDTH{1'b0}};
        end else begin
            stat_q <= stat_d;
        end
    end

    // Pending is a level from the counters, so it clears once all are below half or the interrupt enable is cleared
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= irq_en && half_any; // RQ6 RQ7
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_d & mask_q);
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rd_cnt_q <= 1'b0;
        end else begin
            rd_cnt_q <= reg_rd_i && addr_is_cnt;
        end
    end

    // An idle port and any address outside the map read as zero
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_q <= 32'h0000_0000;
        end else begin
            reg_rdata_q <= 32'h0000_0000;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    erxst_pkg::CTRL_OFS: reg_rdata_q <= link_control_register_q;
                    erxst_pkg::STAT_OFS: reg_rdata_q <= {28'h000_0000, stat_q};
                    erxst_pkg::MASK_OFS: reg_rdata_q <= {28'h000_0000, mask_q};
                    erxst_pkg::MAXLEN_OFS: reg_rdata_q <= {16'h0000, max_rx_frame_length_q};
                    default: reg_rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Counter words come from the bank's own output register
    assign reg_rdata_o = rd_cnt_q ? cif.rd_data : reg_rdata_q;
    assign counter_irq_pending_o = pend_q;
    assign irq_o = irq_q && !rx_unused | irq_q;
endmodule : erxst_top
`default_nettype wire

// ==== inc/erxst_pkg.sv ====
package erxst_pkg;
    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] GOOD_OFS = 8'h00;
    localparam logic [7:0] BCAST_OFS = 8'h04;
    localparam logic [7:0] GROUP_OFS = 8'h08;
    localparam logic [7:0] CTRL_OFS = 8'h10;
    localparam logic [7:0] STAT_OFS = 8'h14;
    localparam logic [7:0] MASK_OFS = 8'h18;
    localparam logic [7:0] MAXLEN_OFS = 8'h1c;
    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_GMII_BIT = 0;
    localparam int CTRL_IRQEN_BIT = 1;
    localparam int EV_GOOD_BIT = 0;
    localparam int EV_BCAST_BIT = 1;
    localparam int EV_GROUP_BIT = 2;
    localparam int EV_HALF_BIT = 3;
    localparam int EV_WIDTH = 4;
    localparam int NUM_CNT = 3;
    localparam logic [31:0] HALF_SCALE = 32'h8000_0000;
    localparam logic [15:0] MIN_FRAME_LEN = 16'h0040;
    localparam logic [15:0] MAXLEN_RESET = 16'h05ee;
    localparam logic [47:0] BCAST_ADDR = 48'hffff_ffff_ffff;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLEAR_DELAY_CYC = 38;
    typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_CHECK} erxst_rx_state_type;
endpackage : erxst_pkg

// ==== inc/erxst_cnt_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface erxst_cnt_if;
    logic [1:0] wr_idx;
    logic wr_en;
    logic [31:0] wr_val;
    logic [2:0] inc;
    logic clr;
    logic [1:0] rd_idx;
    logic [31:0] rd_data;
    logic [2:0] half;
    modport ctl (output wr_idx, output wr_en, output wr_val, output inc, output clr,
                 output rd_idx, input rd_data, input half);
    modport bank (input wr_idx, input wr_en, input wr_val, input inc, input clr,
                  input rd_idx, output rd_data, output half);
endinterface : erxst_cnt_if
`default_nettype wire

// ==== hdl/erxst_counter_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
module erxst_counter_bank #(
    parameter int NUM = 3
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic gmii_en_i,
    erxst_cnt_if.bank cif
);
    logic [31:0] cnt_q [NUM];
    logic [31:0] rd_data_q;

    if (NUM != erxst_pkg::NUM_CNT) begin : g_num_check
        $error("Counter bank size must match the map");
    end

    // Write is applied first, then the increment, so neither is lost
    function automatic logic [31:0] erxst_next(input logic [31:0] cur, input logic wr,
                                               input logic [31:0] val, input logic dec,
                                               input logic inc);
        logic [31:0] base;
        base = cur;
        if (wr) begin
            if (dec) begin
                base = (val > cur) ? 32'h0000_0000 : cur - val; // RQ2 RQ3
            end else begin
                base = val; // RQ4
            end
        end
        erxst_next = base + {31'h0000_0000, inc}; // RQ8 RQ16
    endfunction : erxst_next

    genvar g;
    generate
        for (g = 0; g < NUM; g++) begin : g_cnt
            always_ff @(posedge sys_clk_i) begin
                if (!rst_n_i || cif.clr) begin
                    cnt_q[g] <= 32'h0000_0000; // RQ1
                end else begin
                    cnt_q[g] <= erxst_next(cnt_q[g], cif.wr_en && (cif.wr_idx == 2'(g)),
                                           cif.wr_val, gmii_en_i, cif.inc[g]);
                end
            end
            assign cif.half[g] = cnt_q[g] >= erxst_pkg::HALF_SCALE; // RQ6
        end
    endgenerate

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rd_data_q <= 32'h0000_0000;
        end else begin
            rd_data_q <= (cif.rd_idx < 2'(NUM)) ? cnt_q[cif.rd_idx] : 32'h0000_0000;
        end
    end
    assign cif.rd_data = rd_data_q;
endmodule : erxst_counter_bank
`default_nettype wire

// ==== tb/erxst_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module erxst_assertions (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic rx_done_i,
    input wire logic counter_irq_pending_o,
    input wire logic irq_o
);
    logic gig_q;
    logic irq_en_q;
    logic mask_any_q;
    wire wr_good = reg_wr_i && reg_addr_i == erxst_pkg::GOOD_OFS;
    wire rd_good = reg_rd_i && reg_addr_i == erxst_pkg::GOOD_OFS;
    // Shadow of control and mask, kept from the bus alone
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            gig_q <= 1'b0;
            irq_en_q <= 1'b0;
            mask_any_q <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == erxst_pkg::CTRL_OFS) begin
            gig_q <= reg_wdata_i[erxst_pkg::CTRL_GMII_BIT];
            irq_en_q <= reg_wdata_i[erxst_pkg::CTRL_IRQEN_BIT];
        end else if (reg_wr_i && reg_addr_i == erxst_pkg::MASK_OFS) begin
            mask_any_q <= |reg_wdata_i[3:0];
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside its slot");
    a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 8'h0c |=> reg_rdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_reset_quiet: assert property ($rose(rst_n_i) |-> !counter_irq_pending_o && !irq_o)
        else $error("interrupt high after reset");
    // A frame done at or just before the write would add on top, so it is excluded
    a_direct_load: assert property (wr_good && !gig_q && !$past(rx_done_i) && !rx_done_i
        ##1 !reg_wr_i ##1 rd_good |=> reg_rdata_o == $past(reg_wdata_i, 3))
        else $error("direct write not loaded");
    a_dec_clear: assert property (wr_good && gig_q && reg_wdata_i == 32'hffff_ffff
        && !$past(rx_done_i) && !rx_done_i ##1 !reg_wr_i ##1 rd_good |=> reg_rdata_o == 32'h0)
        else $error("decrement by all ones left a value");
    a_pend_rise: assert property ($past(reg_rd_i) && irq_en_q
        && reg_rdata_o >= erxst_pkg::HALF_SCALE |-> ##[0:2] counter_irq_pending_o)
        else $error("pending flag missing at half scale");
    a_pend_off: assert property (!$past(irq_en_q) |-> !counter_irq_pending_o)
        else $error("pending flag while disabled");
    a_irq_masked: assert property (!$past(mask_any_q) |-> !irq_o)
        else $error("interrupt while fully masked");
    a_pend_fall: assert property ($fell(counter_irq_pending_o) |-> $past(reg_wr_i, 2))
        else $error("pending flag fell without a write");
    c_pend: cover property ($rose(counter_irq_pending_o));
    c_irq: cover property ($rose(irq_o));
    c_read: cover property (rd_good ##1 reg_rdata_o != 32'h0);
endmodule : erxst_assertions
bind erxst_top erxst_assertions u_chk (.sys_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .rx_done_i, .counter_irq_pending_o, .irq_o);
`default_nettype wire

// ==== tb/erxst_rx_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module erxst_rx_model (
    input wire logic sys_clk_i,
    input wire logic start_i,
    input wire logic [47:0] dest_i,
    input wire logic [15:0] len_i,
    input wire logic [6:0] flags_i,
    output logic active_o,
    output logic err_o,
    output logic done_o,
    output logic [47:0] dest_o,
    output logic [15:0] len_o,
    output logic [5:0] flags_o
);
    logic [2:0] ph_q = 3'h0;
    logic [47:0] dest_q = 48'h0;
    logic [15:0] len_q = 16'h0;
    logic [6:0] flags_q = 7'h0;
    always_ff @(posedge sys_clk_i) begin
        if (start_i) begin
            dest_q <= dest_i;
            len_q <= len_i;
            flags_q <= flags_i;
            ph_q <= 3'h1;
        end else if (ph_q != 3'h0) begin
            ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
        end
    end
    assign active_o = ph_q != 3'h0 && ph_q != 3'h5;
    // Error is one mid-frame pulse, so only a latch over the frame sees it
    assign err_o = ph_q == 3'h2 && flags_q[0];
    assign done_o = ph_q == 3'h5;
    // Outside the done cycle the report is inverted so stale fields never pass
    assign dest_o = done_o ? dest_q : ~dest_q;
    assign len_o = done_o ? len_q : ~len_q;
    assign flags_o = done_o ? flags_q[6:1] : ~flags_q[6:1];
endmodule : erxst_rx_model
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic [47:0] dest;
        logic [15:0] len;
        logic [6:0] flags;
        logic [2:0] inc;
    } erxst_row_type;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic start = 1'b0;
    logic [47:0] dest = 48'h0;
    logic [15:0] len = 16'h0;
    logic [6:0] flags = 7'h0;
    logic [31:0] reg_rdata_o, rd_v;
    logic rx_active_i, phy_receive_error_in_i, rx_done_i, rx_addr_match_i, rx_promisc_i;
    logic rx_odd_nibbles_i, rx_fcs_ok_i, rx_fcs_trunc_ok_i, rx_overrun_i;
    logic [47:0] rx_dest_addr_i;
    logic [15:0] rx_length_i;
    logic counter_irq_pending_o, irq_o;
    logic [31:0] exp_cnt [3];
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    // Flags: overrun, promiscuous, match, trunc ok, fcs ok, odd, error; inc: group, bcast, good
    erxst_row_type rows [11] = '{
        '{48'hffff_ffff_ffff, 16'h0040, 7'h14, 3'h3}, '{48'h0100_5e00_0001, 16'h05ee, 7'h24, 3'h5},
        '{48'h0200_0000_0002, 16'h003f, 7'h14, 3'h0}, '{48'h0200_0000_0002, 16'h05ef, 7'h14, 3'h0},
        '{48'h0200_0000_0002, 16'h0040, 7'h10, 3'h0}, '{48'h0200_0000_0002, 16'h0040, 7'h1a, 3'h1},
        '{48'h0200_0000_0002, 16'h0040, 7'h12, 3'h0}, '{48'h0200_0000_0002, 16'h0040, 7'h15, 3'h0},
        '{48'h0200_0000_0002, 16'h0040, 7'h04, 3'h0}, '{48'hffff_ffff_ffff, 16'h0040, 7'h54, 3'h3},
        '{48'hffff_ffff_ff7f, 16'h0040, 7'h14, 3'h5}};
    always #50 sys_clk_i = ~sys_clk_i;
    erxst_top uut (.sys_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .rx_active_i, .phy_receive_error_in_i, .rx_done_i, .rx_addr_match_i,
        .rx_promisc_i, .rx_dest_addr_i, .rx_length_i, .rx_odd_nibbles_i, .rx_fcs_ok_i,
        .rx_fcs_trunc_ok_i, .rx_overrun_i, .counter_irq_pending_o, .irq_o);
    erxst_rx_model rx (.sys_clk_i, .start_i(start), .dest_i(dest), .len_i(len), .flags_i(flags),
        .active_o(rx_active_i), .err_o(phy_receive_error_in_i), .done_o(rx_done_i),
        .dest_o(rx_dest_addr_i), .len_o(rx_length_i), .flags_o({rx_overrun_i, rx_promisc_i,
        rx_addr_match_i, rx_fcs_trunc_ok_i, rx_fcs_ok_i, rx_odd_nibbles_i}));
    task automatic test_done;
        if (n_fail == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 rd_v = reg_rdata_o;
    endtask : rd
    task automatic send(input erxst_row_type r);
        @(posedge sys_clk_i);
        dest <= r.dest;
        len <= r.len;
        flags <= r.flags;
        start <= 1'b1;
        @(posedge sys_clk_i);
        start <= 1'b0;
    endtask : send
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 4000) begin
            n_fail++;
            test_done;
        end
    end
    initial begin
        exp_cnt = '{32'h0, 32'h0, 32'h0};
        repeat (6) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        // An early write must be wiped by the delayed clear
        wr(erxst_pkg::BCAST_OFS, 32'h1234);
        repeat (35) @(posedge sys_clk_i);
        wr(erxst_pkg::GOOD_OFS, 32'h55);
        rd(erxst_pkg::GOOD_OFS);
        chk(rd_v, 32'h55);
        rd(erxst_pkg::BCAST_OFS);
        chk(rd_v, 32'h0);
        wr(erxst_pkg::GOOD_OFS, 32'h0);
        for (int i = 0; i < 11; i++) begin
            send(rows[i]);
            repeat (8) @(posedge sys_clk_i);
            for (int k = 0; k < 3; k++) begin
                exp_cnt[k] = exp_cnt[k] + {31'h0, rows[i].inc[k]};
                rd(8'(4 * k));
                chk(rd_v, exp_cnt[k]);
            end
        end
        send(rows[5]);
        for (int w = 0; w < 10; w++) begin
            @(posedge sys_clk_i);
            #1;
            if (rx_done_i === 1'b1) break;
        end
        wr(erxst_pkg::GOOD_OFS, 32'h5);
        repeat (3) @(posedge sys_clk_i);
        rd(erxst_pkg::GOOD_OFS);
        chk(rd_v, 32'h6);
        wr(erxst_pkg::GOOD_OFS, 32'hffff_ffff);
        send(rows[5]);
        repeat (8) @(posedge sys_clk_i);
        rd(erxst_pkg::GOOD_OFS);
        chk(rd_v, 32'h0);
        wr(erxst_pkg::GOOD_OFS, 32'h100);
        wr(erxst_pkg::CTRL_OFS, 32'h1);
        wr(erxst_pkg::GOOD_OFS, 32'h3);
        rd(erxst_pkg::GOOD_OFS);
        chk(rd_v, 32'hfd);
        wr(erxst_pkg::GOOD_OFS, 32'hffff_ffff);
        rd(erxst_pkg::GOOD_OFS);
        chk(rd_v, 32'h0);
        wr(erxst_pkg::BCAST_OFS, exp_cnt[1] + 32'h1);
        rd(erxst_pkg::BCAST_OFS);
        chk(rd_v, 32'h0);
        wr(erxst_pkg::CTRL_OFS, 32'h2);
        wr(erxst_pkg::MASK_OFS, 32'h8);
        wr(erxst_pkg::GROUP_OFS, 32'h8000_0000);
        rd(erxst_pkg::GROUP_OFS);
        chk(rd_v, 32'h8000_0000);
        repeat (2) @(posedge sys_clk_i);
        #1;
        chk({31'h0, counter_irq_pending_o}, 32'h1);
        chk({31'h0, irq_o}, 32'h1);
        wr(erxst_pkg::CTRL_OFS, 32'h3);
        wr(erxst_pkg::GROUP_OFS, 32'h1);
        repeat (3) @(posedge sys_clk_i);
        #1;
        chk({31'h0, counter_irq_pending_o}, 32'h0);
        rd(erxst_pkg::STAT_OFS);
        chk({31'h0, rd_v[erxst_pkg::EV_HALF_BIT]}, 32'h1);
        repeat (3) @(posedge sys_clk_i);
        #1;
        chk({31'h0, irq_o}, 32'h0);
        rd(8'h0c);
        chk(rd_v, 32'h0);
        test_done;
    end
endmodule : testbench
`default_nettype wire
